// *** src/ccm_pkg.sv ***
// Shared types, constants and helpers for the clean/make line state block
package ccm_pkg;

    // Coherent read response layout
    localparam int unsigned RESP_W          = 4;
    localparam int unsigned RESP_IS_SHARED  = 3;
    localparam int unsigned RESP_PASS_DIRTY = 2;

    typedef enum logic [2:0] {
        LS_I, LS_UC, LS_UD, LS_SC, LS_SD
    } ccm_line_e;

    typedef enum logic [3:0] {
        OP_NONE,
        OP_CLEAN_UNIQUE,
        OP_CLEAN_SHARED,
        OP_CLEAN_INVALID,
        OP_MAKE_UNIQUE,
        OP_MAKE_INVALID,
        OP_WRITE_NO_SNOOP,
        OP_WRITE_BACK,
        OP_WRITE_CLEAN,
        OP_EVICT
    } ccm_op_e;

    typedef enum logic [2:0] {
        ST_IDLE, ST_PREP_AW, ST_PREP_B, ST_AR, ST_R, ST_STORE,
        ST_POST_AW, ST_POST_B
    } ccm_fsm_e;

    typedef struct packed {
        ccm_fsm_e  st;
        ccm_op_e   op;
        ccm_op_e   aw_op;
        ccm_op_e   post_op;
        ccm_line_e line;
        ccm_line_e end_line;
        logic      store;
        logic      full;
        logic      ar_valid;
        logic      aw_valid;
        logic      snoop_ready;
        logic      store_valid;
        logic      cmd_ready;
        logic      done;
        logic      error;
    } ccm_state_s;

    localparam ccm_line_e  LINE_RST  = LS_I;
    localparam ccm_state_s STATE_RST = '{
        st: ST_IDLE, op: OP_NONE, aw_op: OP_NONE, post_op: OP_NONE,
        line: LINE_RST, end_line: LINE_RST, store: 1'b0, full: 1'b0,
        ar_valid: 1'b0, aw_valid: 1'b0, snoop_ready: 1'b1,
        store_valid: 1'b0, cmd_ready: 1'b1, done: 1'b0, error: 1'b0};

    function automatic logic ccm_is_dirty(input ccm_line_e s);
        return (s == LS_UD) || (s == LS_SD);
    endfunction

    function automatic logic ccm_is_valid(input ccm_line_e s);
        return s != LS_I;
    endfunction

    function automatic ccm_line_e ccm_clean_of(input ccm_line_e s);
        case (s)
            LS_UD:   return LS_UC;
            LS_SD:   return LS_SC;
            default: return s;
        endcase
    endfunction

    function automatic ccm_line_e ccm_dirty_of(input ccm_line_e s);
        case (s)
            LS_UC:   return LS_UD;
            LS_SC:   return LS_SD;
            default: return s;
        endcase
    endfunction

endpackage

// *** src/ccm_upd_if.sv ***
// Carries a response lookup between the sequencer and the decoder
`timescale 1ns/1ps
interface ccm_upd_if;
    import ccm_pkg::*;
    ccm_op_e                op;
    ccm_line_e              line;
    logic [RESP_W-1:0]      resp;
    logic                   store;
    logic                   full;
    ccm_line_e              end_line;
    ccm_op_e                post_op;
    logic                   do_store;
    logic                   resp_ok;

    modport requester (output op, line, resp, store, full,
                       input  end_line, post_op, do_store, resp_ok);
    modport decoder   (input  op, line, resp, store, full,
                       output end_line, post_op, do_store, resp_ok);
endinterface

// *** src/ccm_resp_decode.sv ***
// End state lookup for clean and make group responses
`timescale 1ns/1ps
module ccm_resp_decode
    import ccm_pkg::*;
(
    ccm_upd_if.decoder u    // Lookup request and result
);

    always_comb begin
        u.end_line = u.line;
        u.post_op  = OP_NONE;
        u.do_store = 1'b0;
        u.resp_ok  = !u.resp[RESP_IS_SHARED] && !u.resp[RESP_PASS_DIRTY];
        case (u.op)
            OP_CLEAN_SHARED: begin
                u.resp_ok = !u.resp[RESP_PASS_DIRTY];
                // A local write while outstanding keeps the line dirty
                case (u.line)
                    LS_UC, LS_SC: u.end_line = u.resp[RESP_IS_SHARED] ?
                                               LS_SC : LS_UC;
                    LS_UD, LS_SD: u.end_line = u.resp[RESP_IS_SHARED] ?
                                               LS_SD : LS_UD;
                    default:      u.end_line = LS_I;
                endcase
            end
            OP_CLEAN_UNIQUE: begin
                if (ccm_is_valid(u.line)) begin
                    u.do_store = u.store;
                    u.end_line = u.store ? LS_UD : ccm_dirty_of(
                                 ccm_clean_of(u.line) == LS_SC ? LS_UC :
                                 ccm_clean_of(u.line));
                    if (!u.store)
                        u.end_line = (u.line == LS_SD) ? LS_UD :
                                     (u.line == LS_SC) ? LS_UC : u.line;
                end else if (u.store) begin
                    u.do_store = 1'b1;
                    u.end_line = u.full ? LS_UD : LS_I;
                    u.post_op  = u.full ? OP_NONE : OP_WRITE_BACK;
                end else begin
                    u.end_line = LS_I;
                    u.post_op  = OP_EVICT;
                end
            end
            OP_MAKE_UNIQUE: begin
                u.do_store = 1'b1;
                u.end_line = LS_UD;
            end
            default: u.end_line = LS_I;
        endcase
    end

endmodule // ccm_resp_decode

// *** src/ccm_clean_make.sv ***
// Line state sequencer for clean and make group transactions
`timescale 1ns/1ps
module ccm_clean_make
    import ccm_pkg::*;
(
    input  wire logic              i_clock,         // 40 MHz clock
    input  wire logic              i_rst_b,         // Async reset, low
    input  wire logic              i_clk_en,        // Freezes state when low
    input  wire logic              i_cmd_valid,     // Command request
    input  wire ccm_op_e           i_cmd_op,        // Requested transaction
    input  wire logic              i_cmd_shareable, // Target is shareable
    input  wire logic              i_cmd_store,     // Store follows
    input  wire logic              i_cmd_full,      // Store covers line
    output logic                   o_cmd_ready,     // Idle, takes command
    input  wire logic              i_local_store,   // Local write to line
    output logic                   o_ar_valid,      // Read address valid
    output ccm_op_e                o_ar_op,         // Read address opcode
    input  wire logic              i_ar_ready,      // Read address ready
    input  wire logic              i_r_valid,       // Read response valid
    input  wire logic [RESP_W-1:0] i_r_resp,        // Read response code
    output logic                   o_aw_valid,      // Write address valid
    output ccm_op_e                o_aw_op,         // Write address opcode
    input  wire logic              i_aw_ready,      // Write address ready
    input  wire logic              i_b_valid,       // Write response valid
    input  wire logic              i_snoop_valid,   // Invalidating snoop
    output logic                   o_snoop_ready,   // Snoop accepted
    output logic                   o_store_valid,   // Do the line store
    output logic                   o_store_full,    // That store is full
    output ccm_line_e              o_line_state,    // Tracked line state
    output logic                   o_done,          // Command finished
    output logic                   o_error          // Refused or bad resp
);

    ccm_state_s q;
    ccm_state_s n;
    ccm_line_e  line_cur;
    logic       cmd_legal;

    ccm_upd_if u ();

    ccm_resp_decode u_decode (
        .u (u.decoder)
    );

    // Snoops here only invalidate; a dirty victim's data is not modelled
    always_comb begin
        line_cur = q.line;
        if (q.st == ST_R && i_local_store && q.op == OP_CLEAN_SHARED)
            line_cur = ccm_dirty_of(q.line);
        if (i_snoop_valid && q.snoop_ready)
            line_cur = LS_I;
    end

    assign u.op    = q.op;
    assign u.line  = line_cur;
    assign u.resp  = i_r_resp;
    assign u.store = q.store;
    assign u.full  = q.full;

    always_comb begin
        case (i_cmd_op)
            OP_CLEAN_UNIQUE:   cmd_legal = i_cmd_shareable;
            OP_MAKE_UNIQUE:    cmd_legal = i_cmd_shareable && i_cmd_store
                                           && i_cmd_full;
            OP_CLEAN_SHARED,
            OP_CLEAN_INVALID,
            OP_MAKE_INVALID:   cmd_legal = 1'b1;
            OP_WRITE_NO_SNOOP: cmd_legal = !i_cmd_shareable;
            default:           cmd_legal = 1'b0;
        endcase
    end

    // Either start the trailing write or close the command
    function automatic ccm_state_s finish(input ccm_state_s s,
                                          input ccm_op_e post);
        ccm_state_s r;
        r = s;
        if (post != OP_NONE) begin
            r.st       = ST_POST_AW;
            r.aw_valid = 1'b1;
            r.aw_op    = post;
        end else begin
            r.st        = ST_IDLE;
            r.done      = 1'b1;
            r.cmd_ready = 1'b1;
        end
        return r;
    endfunction

    always_comb begin
        n             = q;
        n.done        = 1'b0;
        n.error       = 1'b0;
        n.store_valid = 1'b0;
        n.line        = line_cur;
        case (q.st)
            ST_IDLE: begin
                if (i_cmd_valid) begin
                    n.op    = i_cmd_op;
                    n.store = i_cmd_store;
                    n.full  = i_cmd_full;
                    if (!cmd_legal) begin
                        n.done  = 1'b1;
                        n.error = 1'b1;
                    end else begin
                        n.cmd_ready = 1'b0;
                        n.st        = ST_AR;
                        n.ar_valid  = 1'b1;
                        case (i_cmd_op)
                            OP_CLEAN_SHARED, OP_CLEAN_INVALID: begin
                                if (ccm_is_dirty(line_cur)) begin
                                    n.st       = ST_PREP_AW;
                                    n.ar_valid = 1'b0;
                                    n.aw_valid = 1'b1;
                                    n.aw_op    = (i_cmd_op == OP_CLEAN_SHARED)
                                                 ? OP_WRITE_CLEAN
                                                 : OP_WRITE_BACK;
                                end else if (i_cmd_op == OP_CLEAN_INVALID) begin
                                    n.line = LS_I;
                                end
                            end
                            OP_MAKE_INVALID: n.line = LS_I;
                            OP_WRITE_NO_SNOOP: begin
                                n.st       = ST_POST_AW;
                                n.ar_valid = 1'b0;
                                n.aw_valid = 1'b1;
                                n.aw_op    = OP_WRITE_NO_SNOOP;
                            end
                            default: n.st = ST_AR;
                        endcase
                    end
                end
            end
            ST_PREP_AW: begin
                if (i_aw_ready) begin
                    n.aw_valid = 1'b0;
                    n.st       = ST_PREP_B;
                end
            end
            ST_PREP_B: begin
                if (i_b_valid) begin
                    n.line     = (q.aw_op == OP_WRITE_CLEAN) ?
                                 ccm_clean_of(line_cur) : LS_I;
                    n.st       = ST_AR;
                    n.ar_valid = 1'b1;
                end
            end
            ST_AR: begin
                if (i_ar_ready) begin
                    n.ar_valid = 1'b0;
                    n.st       = ST_R;
                end
            end
            ST_R: begin
                if (i_r_valid) begin
                    n.error    = !u.resp_ok;
                    n.end_line = u.end_line;
                    n.post_op  = u.post_op;
                    if (u.do_store) begin
                        // Snoops wait from the cycle after completion
                        n.st          = ST_STORE;
                        n.store_valid = 1'b1;
                        n.snoop_ready = 1'b0;
                    end else begin
                        n.line = u.end_line;
                        n      = finish(n, u.post_op);
                    end
                end
            end
            ST_STORE: begin
                n.line        = q.end_line;
                n.snoop_ready = 1'b1;
                n             = finish(n, q.post_op);
            end
            ST_POST_AW: begin
                if (i_aw_ready) begin
                    n.aw_valid = 1'b0;
                    n.st       = ST_POST_B;
                end
            end
            ST_POST_B: begin
                if (i_b_valid) begin
                    if (q.op == OP_WRITE_NO_SNOOP && ccm_is_valid(line_cur))
                        n.line = LS_UC;
                    n.st        = ST_IDLE;
                    n.done      = 1'b1;
                    n.cmd_ready = 1'b1;
                end
            end
            default: n = STATE_RST;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            q <= STATE_RST;
        end else if (i_clk_en) begin
            q <= n;
        end
    end

    assign o_cmd_ready   = q.cmd_ready;
    assign o_ar_valid    = q.ar_valid;
    assign o_ar_op       = q.op;
    assign o_aw_valid    = q.aw_valid;
    assign o_aw_op       = q.aw_op;
    assign o_snoop_ready = q.snoop_ready;
    assign o_store_valid = q.store_valid;
    assign o_store_full  = q.full;
    assign o_line_state  = q.line;
    assign o_done        = q.done;
    assign o_error       = q.error;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);

    sequence resp_store_s;
        q.st == ST_R && i_r_valid && i_clk_en && u.do_store;
    endsequence

    sequence store_held_s;
        o_store_valid && !o_snoop_ready;
    endsequence

    sequence cu_resp_s;
        q.st == ST_R && i_r_valid && i_clk_en && q.op == OP_CLEAN_UNIQUE;
    endsequence

    cu_full_store_a: assert property (
        (q.st == ST_STORE && q.op == OP_CLEAN_UNIQUE && q.full && i_clk_en)
        |=> o_line_state == LS_UD && o_snoop_ready)
        else $error("full store after CleanUnique did not give UD");

    snoop_hold_a: assert property (
        resp_store_s |=> store_held_s)
        else $error("snoop not held during post-completion store");

    evict_issue_a: assert property (
        cu_resp_s and (line_cur == LS_I && !q.store)
        |=> o_aw_valid && o_aw_op == OP_EVICT && o_line_state == LS_I)
        else $error("missing Evict after unused CleanUnique");

    partial_wb_a: assert property (
        (q.st == ST_STORE && q.op == OP_CLEAN_UNIQUE && !q.full && i_clk_en)
        |=> o_aw_valid && o_aw_op == OP_WRITE_BACK)
        else $error("partial store on unallocated line not written back");

    cs_clean_a: assert property (
        (o_ar_valid && o_ar_op == OP_CLEAN_SHARED)
        |-> !ccm_is_dirty(o_line_state))
        else $error("CleanShared issued for a dirty line");

    cs_update_a: assert property (
        (q.st == ST_R && i_r_valid && i_clk_en && q.op == OP_CLEAN_SHARED
         && (line_cur == LS_UC || line_cur == LS_SC))
        // Response code has moved on by the next edge, so look back
        |=> o_line_state == ($past(i_r_resp[RESP_IS_SHARED])
                             ? LS_SC : LS_UC) && o_done)
        else $error("CleanShared end state wrong");

    inval_issue_a: assert property (
        (o_ar_valid && (o_ar_op == OP_CLEAN_INVALID
                        || o_ar_op == OP_MAKE_INVALID))
        |-> o_line_state == LS_I)
        else $error("invalidating request issued with valid line");

    inval_end_a: assert property (
        (q.st == ST_R && i_r_valid && i_clk_en
         && (q.op == OP_CLEAN_INVALID || q.op == OP_MAKE_INVALID))
        |=> o_line_state == LS_I && o_done && o_cmd_ready)
        else $error("invalidating request did not end Invalid");

    mu_refuse_a: assert property (
        (q.st == ST_IDLE && i_cmd_valid && i_clk_en
         && i_cmd_op == OP_MAKE_UNIQUE && !(i_cmd_full && i_cmd_shareable))
        |=> o_error && o_done && !o_ar_valid ##1 !o_error)
        else $error("illegal MakeUnique not refused");

    mu_unique_a: assert property (
        (q.st == ST_STORE && q.op == OP_MAKE_UNIQUE && i_clk_en)
        |=> o_line_state == LS_UD && o_done)
        else $error("MakeUnique did not end UD");

    channel_a: assert property (
        o_aw_valid |-> (o_aw_op inside {OP_WRITE_BACK, OP_WRITE_CLEAN,
                        OP_EVICT, OP_WRITE_NO_SNOOP}) && !o_ar_valid)
        else $error("wrong channel for opcode");

    wns_refuse_a: assert property (
        (q.st == ST_IDLE && i_cmd_valid && i_clk_en
         && i_cmd_op == OP_WRITE_NO_SNOOP && i_cmd_shareable)
        |=> o_error && !o_aw_valid)
        else $error("shareable WriteNoSnoop not refused");

    resp_bits_a: assert property (
        (q.st == ST_R && i_r_valid && i_clk_en
         && q.op == OP_CLEAN_SHARED && i_r_resp[3:2] == 2'b01)
        |=> o_error)
        else $error("PassDirty on CleanShared not flagged");

endmodule // ccm_clean_make

// *** testbench/ccm_ic_model.sv ***
// Behavioural coherent interconnect facing the clean/make block
`timescale 1ns/1ps
module ccm_ic_model
    import ccm_pkg::*;
(
    input  wire logic              i_clock,    // Clock
    input  wire logic              i_rst_b,    // Reset, low
    input  wire logic              i_ar_valid, // Read address valid
    input  wire logic              i_aw_valid, // Write address valid
    input  wire logic [RESP_W-1:0] i_code,     // Response to give
    input  wire logic [1:0]        i_wait,     // Answer delay
    output logic                   o_ar_ready, // Read address taken
    output logic                   o_r_valid,  // Read response
    output logic [RESP_W-1:0]      o_r_resp,   // Response code
    output logic                   o_aw_ready, // Write address taken
    output logic                   o_b_valid   // Write response
);
    logic [1:0] cnt_q;
    logic       r_pend_q;
    logic       b_pend_q;

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_q      <= 2'h0;
            r_pend_q   <= 1'b0;
            b_pend_q   <= 1'b0;
            o_ar_ready <= 1'b0;
            o_r_valid  <= 1'b0;
            o_r_resp   <= 4'h0;
            o_aw_ready <= 1'b0;
            o_b_valid  <= 1'b0;
        end else begin
            o_ar_ready <= 1'b0;
            o_r_valid  <= 1'b0;
            o_aw_ready <= 1'b0;
            o_b_valid  <= 1'b0;
            // Idle code wanders so a stale value never passes
            o_r_resp   <= ~o_r_resp;
            if (cnt_q != 2'h0) begin
                cnt_q <= cnt_q - 2'h1;
            end else if (r_pend_q) begin
                // Bit 3 shared, bit 2 dirty
                o_r_valid <= 1'b1;
                o_r_resp  <= i_code;
                r_pend_q  <= 1'b0;
            end else if (b_pend_q) begin
                o_b_valid <= 1'b1;
                b_pend_q  <= 1'b0;
            end else if (i_ar_valid && !o_ar_ready) begin
                o_ar_ready <= 1'b1;
                r_pend_q   <= 1'b1;
                cnt_q      <= i_wait;
            end else if (i_aw_valid && !o_aw_ready) begin
                o_aw_ready <= 1'b1;
                b_pend_q   <= 1'b1;
                cnt_q      <= i_wait;
            end
        end
    end
endmodule // ccm_ic_model

// *** testbench/ccm_clean_make_bench.sv ***
// Self-checking bench for the clean/make line state block
`timescale 1ns/1ps
module ccm_clean_make_bench
    import ccm_pkg::*;
;
    logic        clk = 1'b0, rst_b = 1'b0, cmd_valid = 1'b0;
    ccm_op_e     cmd_op = OP_NONE, cur_op = OP_NONE, ar_op, aw_op;
    logic        cmd_sh = 1'b0, cmd_st = 1'b0, cmd_fu = 1'b0;
    logic        local_st = 1'b0, snoop_on = 1'b0, snoop_valid = 1'b0;
    logic        clk_en = 1'b1;
    logic [3:0]  code = 4'h0, r_resp;
    logic [1:0]  wait_c = 2'h0;
    logic        cmd_ready, ar_valid, ar_ready, r_valid, aw_valid;
    logic        aw_ready, b_valid, snoop_ready, store_valid, store_full;
    logic        done, err;
    ccm_line_e   line;
    logic [3:0]  exp_q[$];
    int          bad_count = 0, checks = 0, seed = 43281;

    always #12.5 clk = ~clk;

    ccm_clean_make dut (.i_clock(clk), .i_rst_b(rst_b), .i_clk_en(clk_en),
        .i_cmd_valid(cmd_valid), .i_cmd_op(cmd_op),
        .i_cmd_shareable(cmd_sh), .i_cmd_store(cmd_st),
        .i_cmd_full(cmd_fu), .o_cmd_ready(cmd_ready),
        .i_local_store(local_st), .o_ar_valid(ar_valid), .o_ar_op(ar_op),
        .i_ar_ready(ar_ready), .i_r_valid(r_valid), .i_r_resp(r_resp),
        .o_aw_valid(aw_valid), .o_aw_op(aw_op), .i_aw_ready(aw_ready),
        .i_b_valid(b_valid), .i_snoop_valid(snoop_valid),
        .o_snoop_ready(snoop_ready), .o_store_valid(store_valid),
        .o_store_full(store_full), .o_line_state(line), .o_done(done),
        .o_error(err));

    ccm_ic_model ic (.i_clock(clk), .i_rst_b(rst_b), .i_ar_valid(ar_valid),
        .i_aw_valid(aw_valid), .i_code(code), .i_wait(wait_c),
        .o_ar_ready(ar_ready), .o_r_valid(r_valid), .o_r_resp(r_resp),
        .o_aw_ready(aw_ready), .o_b_valid(b_valid));

    // Snoop lands in the store cycle only, where it must wait
    always @(posedge clk) snoop_valid <= snoop_on & r_valid;

    task automatic close_out();
        $display("Compares %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check_res(logic [3:0] e, logic [3:0] s);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("Error error_and_line expected %0h seen %0h", e, s);
        end
    endtask

    task automatic check_op(string nm, ccm_op_e e, ccm_op_e s);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("Error %s expected %0h seen %0h", nm, e, s);
        end
    endtask

    // Write opcode each command must put on the write channel
    function automatic ccm_op_e exp_aw();
        case (cur_op)
            OP_CLEAN_SHARED:  return OP_WRITE_CLEAN;
            OP_CLEAN_INVALID: return OP_WRITE_BACK;
            OP_CLEAN_UNIQUE:  return cmd_st ? OP_WRITE_BACK : OP_EVICT;
            default:          return cur_op;
        endcase
    endfunction

    task automatic check_bit(string nm, logic e, logic s);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("Error %s expected %0b seen %0b", nm, e, s);
        end
    endtask

    always @(negedge clk) begin
        if (done === 1'b1) begin
            if (exp_q.size() == 0) begin
                check_res(4'hf, {err, line});
            end else begin
                check_res(exp_q.pop_front(), {err, line});
            end
        end
        if (ar_valid === 1'b1) check_op("ar_op", cur_op, ar_op);
        if (aw_valid === 1'b1) check_op("aw_op", exp_aw(), aw_op);
        if (store_valid === 1'b1) begin
            check_bit("snoop_ready", 1'b0, snoop_ready);
            check_bit("store_full", cmd_fu, store_full);
        end
    end

    task automatic cmd(ccm_op_e op, logic sh, st, fu, logic [1:0] rs,
                       logic ls, sn, er, ccm_line_e ln);
        int n;
        int w;
        w = $random(seed);
        exp_q.push_back({er, ln});
        cur_op    <= op;
        cmd_op    <= op;
        cmd_sh    <= sh;
        cmd_st    <= st;
        cmd_fu    <= fu;
        code      <= {rs, w[1:0]};
        wait_c    <= w[3:2];
        local_st  <= ls;
        snoop_on  <= sn;
        cmd_valid <= 1'b1;
        // Random stall on the take edge; the command must wait it out
        clk_en    <= w[4];
        @(posedge clk);
        clk_en    <= 1'b1;
        if (!w[4]) @(posedge clk);
        cmd_valid <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (done !== 1'b1 && n < 100);
        if (done !== 1'b1) begin
            bad_count++;
            close_out();
        end
        @(posedge clk);
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        check_bit("cmd_ready", 1'b1, cmd_ready);
        check_bit("line_idle", 1'b1, line === LS_I);
        @(posedge clk);
        cmd(OP_MAKE_UNIQUE, 1, 1, 1, 2'h0, 0, 1, 0, LS_UD);
        cmd(OP_CLEAN_SHARED, 1, 0, 0, 2'h0, 0, 0, 0, LS_UC);
        cmd(OP_CLEAN_SHARED, 1, 0, 0, 2'h2, 0, 0, 0, LS_SC);
        cmd(OP_CLEAN_SHARED, 1, 0, 0, 2'h0, 1, 0, 0, LS_UD);
        cmd(OP_WRITE_NO_SNOOP, 0, 0, 0, 2'h0, 0, 0, 0, LS_UC);
        cmd(OP_CLEAN_SHARED, 0, 0, 0, 2'h2, 0, 0, 0, LS_SC);
        cmd(OP_CLEAN_UNIQUE, 1, 0, 0, 2'h0, 0, 0, 0, LS_UC);
        cmd(OP_MAKE_INVALID, 1, 0, 0, 2'h0, 0, 0, 0, LS_I);
        cmd(OP_CLEAN_UNIQUE, 1, 1, 1, 2'h0, 0, 1, 0, LS_UD);
        cmd(OP_CLEAN_INVALID, 1, 0, 0, 2'h0, 0, 0, 0, LS_I);
        cmd(OP_CLEAN_UNIQUE, 1, 0, 0, 2'h0, 0, 0, 0, LS_I);
        cmd(OP_CLEAN_UNIQUE, 1, 1, 0, 2'h0, 0, 0, 0, LS_I);
        cmd(OP_MAKE_UNIQUE, 1, 1, 0, 2'h0, 0, 0, 1, LS_I);
        cmd(OP_MAKE_UNIQUE, 0, 1, 1, 2'h0, 0, 0, 1, LS_I);
        cmd(OP_WRITE_NO_SNOOP, 1, 0, 0, 2'h0, 0, 0, 1, LS_I);
        cmd(OP_EVICT, 1, 0, 0, 2'h0, 0, 0, 1, LS_I);
        cmd(OP_CLEAN_INVALID, 1, 0, 0, 2'h2, 0, 0, 1, LS_I);
        cmd(OP_MAKE_INVALID, 1, 0, 0, 2'h1, 0, 0, 1, LS_I);
        cmd(OP_CLEAN_SHARED, 1, 0, 0, 2'h0, 0, 0, 0, LS_I);
        cmd(OP_CLEAN_SHARED, 1, 0, 0, 2'h1, 0, 0, 1, LS_I);
        repeat (4) @(posedge clk);
        check_bit("queue_empty", 1'b1, exp_q.size() == 0);
        close_out();
    end
endmodule // ccm_clean_make_bench
